// >>> src/combo_mem_host.sv
// host controller for the combined flash and static-ram memory device
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - host never drives flash and ram selects low together
// - ram read needs ram select and gate low with write strobe high
// - both strobe and select stay low across the whole write window
// - output gate is held at a firm level during ram writes
// - flash read needs flash select and gate low with strobe high
// - flash command load pulses strobe low, flash select low, gate high
module combo_mem_host #(
  parameter int RAM_DEPTH = combo_host_pkg::RAM_DEPTH_LARGE,
  parameter int ERASE_TIMEOUT_CYCLES = 1000000,
  parameter logic [7:0] UNLOCK_DATA_A = 8'hAA,
  parameter logic [7:0] UNLOCK_DATA_B = 8'h55,
  parameter logic [7:0] PROGRAM_CODE = 8'hA0,
  parameter logic [7:0] ERASE_SETUP_CODE = 8'h80
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // user command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire combo_host_pkg::op_t cmd_op,
  input wire logic [combo_host_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [combo_host_pkg::DATA_W-1:0] cmd_wdata,
  // user answer port
  output logic resp_valid,
  output logic resp_error,
  output logic [combo_host_pkg::DATA_W-1:0] resp_rdata,
  output logic flash_busy,
  output logic flash_done,
  output logic flash_error,
  // memory pins
  output logic [combo_host_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [combo_host_pkg::DATA_W-1:0] dq_in,
  output logic [combo_host_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe_n,
  output logic we_n,
  output logic oe_n,
  output logic flash_bank_select_n,
  output logic ram_bank_select_n,
  output logic shared_gate_select_pin
);
  import combo_host_pkg::*;

  initial
  begin
    if (RAM_DEPTH != RAM_DEPTH_LARGE && RAM_DEPTH != RAM_DEPTH_SMALL)
      $error("unsupported ram depth");
    if (ERASE_TIMEOUT_CYCLES < 1 || ERASE_TIMEOUT_CYCLES >= (1 << TIMER_W))
      $error("erase timeout does not fit the timer");
  end

  // address of load idx of a protected sequence
  function automatic logic [ADDR_W-1:0] seq_addr(op_t op, logic [2:0] idx, logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] r;
    r = (idx == 3'h1 || idx == 3'h4) ? UNLOCK_ADDR_B : UNLOCK_ADDR_A;
    if (op == OP_PROGRAM && idx == PROGRAM_LAST_LOAD)
      r = a;
    if (op == OP_SECTOR_ERASE && idx == ERASE_LAST_LOAD)
      r = {a[ADDR_W-1:SECTOR_OFFSET_BITS], 12'h000};
    if (op == OP_BANK_ERASE && idx == ERASE_LAST_LOAD)
      r = UNLOCK_ADDR_A;
    return r;
  endfunction

  // only valid bytes are issued, so the device never aborts a sequence
  function automatic logic [DATA_W-1:0] seq_data(op_t op, logic [2:0] idx, logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] r;
    r = idx[0] ? UNLOCK_DATA_B : UNLOCK_DATA_A;
    case (idx)
      3'h2: r = (op == OP_PROGRAM) ? PROGRAM_CODE : ERASE_SETUP_CODE;
      3'h3: r = (op == OP_PROGRAM) ? d : UNLOCK_DATA_A;
      3'h4: r = UNLOCK_DATA_B;
      3'h5: r = (op == OP_SECTOR_ERASE) ? SECTOR_ERASE_CODE : BANK_ERASE_CODE;
      default: r = idx[0] ? UNLOCK_DATA_B : UNLOCK_DATA_A;
    endcase
    return r;
  endfunction

  function automatic logic is_flash_write(op_t op);
    return op == OP_PROGRAM || op == OP_SECTOR_ERASE || op == OP_BANK_ERASE;
  endfunction

  typedef enum {M_IDLE, M_ACCESS, M_LOAD, M_POLL} host_state_t;
  host_state_t state_reg, state_next;
  op_t op_reg, op_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [2:0] idx_reg, idx_next;
  logic busy_reg, busy_next, erase_reg, erase_next, prev6_reg, prev6_next, have_prev_reg, have_prev_next;
  logic [TIMER_W-1:0] tcnt_reg, tcnt_next;
  logic resp_valid_reg, resp_valid_next, resp_error_reg, resp_error_next;
  logic fdone_reg, fdone_next, ferr_reg, ferr_next;
  logic accept, ram_op, bad_addr, last_load, status_ok;
  logic eng_start, eng_wr, eng_flash, eng_ready, eng_done;
  logic [ADDR_W-1:0] eng_addr;
  logic [DATA_W-1:0] eng_wdata, eng_rdata;
  logic [TIMER_W-1:0] limit;

  //////////////////////////////////////////////////////////////////////////////
  assign ram_op = (cmd_op == OP_RAM_READ) || (cmd_op == OP_RAM_WRITE);
  assign bad_addr = ram_op && (int'(cmd_addr) >= RAM_DEPTH);
  // flash commands wait while busy; ram ones pass through
  assign cmd_ready = (state_reg == M_IDLE) && eng_ready && (ram_op || !busy_reg);
  assign accept = cmd_valid && cmd_ready;
  assign last_load = idx_reg == (erase_reg ? ERASE_LAST_LOAD : PROGRAM_LAST_LOAD);
  assign limit = erase_reg ? TIMER_W'(ERASE_TIMEOUT_CYCLES) : TIMER_W'(PROGRAM_TIMEOUT_CYCLES);
  // completion: toggle stopped and bit seven showing final value
  assign status_ok = have_prev_reg && (eng_rdata[6] == prev6_reg)
    && (eng_rdata[7] == (erase_reg ? 1'b1 : wdata_reg[7]));

  always_comb
  begin
    eng_start = 1'b0;
    eng_wr = 1'b0;
    eng_flash = 1'b1;
    eng_addr = addr_reg;
    eng_wdata = wdata_reg;
    case (state_reg)
      M_IDLE:
      begin
        if (accept && !bad_addr && !is_flash_write(cmd_op))
        begin
          eng_start = 1'b1;
          eng_wr = cmd_op == OP_RAM_WRITE;
          eng_flash = !ram_op;
          eng_addr = cmd_addr;
          eng_wdata = cmd_wdata;
        end
        else if (!accept && busy_reg && eng_ready)
          eng_start = 1'b1; // status poll read
      end
      M_LOAD:
      begin
        eng_start = eng_ready && !eng_done;
        eng_wr = 1'b1;
        eng_addr = seq_addr(op_reg, idx_reg, addr_reg);
        eng_wdata = seq_data(op_reg, idx_reg, wdata_reg);
      end
      default:
      begin
        eng_start = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    state_next = state_reg;
    op_next = op_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    idx_next = idx_reg;
    busy_next = busy_reg;
    erase_next = erase_reg;
    prev6_next = prev6_reg;
    have_prev_next = have_prev_reg;
    tcnt_next = tcnt_reg;
    resp_valid_next = 1'b0;
    resp_error_next = resp_error_reg;
    fdone_next = 1'b0;
    ferr_next = ferr_reg;
    // the device runs the operation alone; host only times and polls it
    if (busy_reg)
      tcnt_next = tcnt_reg + 1'b1;
    case (state_reg)
      M_IDLE:
      begin
        if (accept)
        begin
          op_next = cmd_op;
          if (bad_addr)
          begin
            resp_valid_next = 1'b1;
            resp_error_next = 1'b1;
          end
          else if (is_flash_write(cmd_op))
          begin
            addr_next = cmd_addr;
            wdata_next = cmd_wdata;
            erase_next = cmd_op != OP_PROGRAM;
            idx_next = 3'h0;
            state_next = M_LOAD;
          end
          else
            state_next = M_ACCESS;
        end
        else if (eng_start)
          state_next = M_POLL;
      end
      M_ACCESS:
      begin
        if (eng_done)
        begin
          resp_valid_next = 1'b1;
          resp_error_next = 1'b0;
          rdata_next = eng_rdata;
          state_next = M_IDLE;
        end
      end
      M_LOAD:
      begin
        if (eng_done)
        begin
          idx_next = idx_reg + 3'h1;
          if (last_load)
          begin
            busy_next = 1'b1;
            tcnt_next = '0;
            have_prev_next = 1'b0;
            state_next = M_IDLE;
          end
        end
      end
      M_POLL:
      begin
        if (eng_done)
        begin
          prev6_next = eng_rdata[6];
          have_prev_next = 1'b1;
          if (status_ok && busy_reg)
          begin
            busy_next = 1'b0;
            fdone_next = 1'b1;
            ferr_next = 1'b0;
          end
          state_next = M_IDLE;
        end
      end
      default: state_next = M_IDLE;
    endcase
    if (busy_reg && tcnt_reg >= limit && !fdone_next)
    begin
      busy_next = 1'b0;
      fdone_next = 1'b1;
      ferr_next = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_reg <= M_IDLE;
      op_reg <= OP_RAM_READ;
      addr_reg <= 19'h0_0000;
      wdata_reg <= 8'h00;
      rdata_reg <= 8'h00;
      idx_reg <= 3'h0;
      busy_reg <= 1'b0;
      erase_reg <= 1'b0;
      prev6_reg <= 1'b0;
      have_prev_reg <= 1'b0;
      tcnt_reg <= '0;
      resp_valid_reg <= 1'b0;
      resp_error_reg <= 1'b0;
      fdone_reg <= 1'b0;
      ferr_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      idx_reg <= idx_next;
      busy_reg <= busy_next;
      erase_reg <= erase_next;
      prev6_reg <= prev6_next;
      have_prev_reg <= have_prev_next;
      tcnt_reg <= tcnt_next;
      resp_valid_reg <= resp_valid_next;
      resp_error_reg <= resp_error_next;
      fdone_reg <= fdone_next;
      ferr_reg <= ferr_next;
    end
  end

  assign resp_valid = resp_valid_reg;
  assign resp_error = resp_error_reg;
  assign resp_rdata = rdata_reg;
  assign flash_busy = busy_reg;
  assign flash_done = fdone_reg;
  assign flash_error = ferr_reg;

  //////////////////////////////////////////////////////////////////////////////
  // idle bus has both selects high, so the device stays in standby
  flash_bus_cycle flash_bus_cycle_i (
    .clk(clk),
    .resetn(resetn),
    .start(eng_start),
    .wr(eng_wr),
    .to_flash(eng_flash),
    .addr(eng_addr),
    .wdata(eng_wdata),
    .ready(eng_ready),
    .done(eng_done),
    .rdata(eng_rdata),
    .mem_addr(mem_addr),
    .dq_in(dq_in),
    .dq_out(dq_out),
    .dq_oe_n(dq_oe_n),
    .we_n(we_n),
    .oe_n(oe_n),
    .flash_bank_select_n(flash_bank_select_n),
    .ram_bank_select_n(ram_bank_select_n),
    .shared_gate_select_pin(shared_gate_select_pin)
  );

  //////////////////////////////////////////////////////////////////////////////
  property p_program_bound;
    @(posedge clk) disable iff (!resetn) busy_reg && !erase_reg |-> tcnt_reg <= TIMER_W'(PROGRAM_TIMEOUT_CYCLES);
  endproperty
  a_program_bound: assert property (p_program_bound) else $error("program wait beyond 20 us");

  property p_flash_stall;
    @(posedge clk) disable iff (!resetn) busy_reg && eng_start && eng_flash |-> !eng_wr;
  endproperty
  a_flash_stall: assert property (p_flash_stall) else $error("flash write issued while busy");
endmodule // combo_mem_host
`default_nettype wire

// >>> src/combo_host_pkg.sv
// constants, timing and command set for the combined-memory host controller
package combo_host_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  // timing: clock and worst-case access of the slower variant
  localparam int CLK_PERIOD_NS = 100;
  localparam int ACCESS_NS = 300;
  localparam int STROBE_CYCLES = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROGRAM_MAX_US = 20;
  localparam int PROGRAM_TIMEOUT_CYCLES = (PROGRAM_MAX_US * 1000) / CLK_PERIOD_NS;
  // bank depths
  localparam int FLASH_DEPTH = 524288;
  localparam int RAM_DEPTH_LARGE = 131072;
  localparam int RAM_DEPTH_SMALL = 32768;
  localparam int SECTOR_OFFSET_BITS = 12;
  // protected command sequence
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_A = 19'h5_5555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_B = 19'h0_2AAA;
  localparam logic [DATA_W-1:0] SECTOR_ERASE_CODE = 8'h30;
  localparam logic [DATA_W-1:0] BANK_ERASE_CODE = 8'h10;
  localparam logic [2:0] PROGRAM_LAST_LOAD = 3'h3;
  localparam logic [2:0] ERASE_LAST_LOAD = 3'h5;
  localparam int TIMER_W = 24;

  typedef enum logic [2:0] {
    OP_RAM_READ,
    OP_RAM_WRITE,
    OP_FLASH_READ,
    OP_PROGRAM,
    OP_SECTOR_ERASE,
    OP_BANK_ERASE
  } op_t;
endpackage

// >>> src/flash_bus_cycle.sv
// one read or write cycle on the shared memory bus
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // cycle request
  input wire logic start,
  input wire logic wr,
  input wire logic to_flash,
  input wire logic [combo_host_pkg::ADDR_W-1:0] addr,
  input wire logic [combo_host_pkg::DATA_W-1:0] wdata,
  output logic ready,
  output logic done,
  output logic [combo_host_pkg::DATA_W-1:0] rdata,
  // memory pins
  output logic [combo_host_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [combo_host_pkg::DATA_W-1:0] dq_in,
  output logic [combo_host_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe_n,
  output logic we_n,
  output logic oe_n,
  output logic flash_bank_select_n,
  output logic ram_bank_select_n,
  output logic shared_gate_select_pin
);
  import combo_host_pkg::*;

  typedef enum {S_IDLE, S_SETUP, S_STROBE, S_RECOVER} cyc_state_t;
  cyc_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic wr_reg, wr_next, done_reg, done_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next, dq_out_reg, dq_out_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic dq_oe_n_reg, dq_oe_n_next, we_n_reg, we_n_next, oe_n_reg, oe_n_next;
  logic fsel_n_reg, fsel_n_next, rsel_n_reg, rsel_n_next;

  initial if (STROBE_CYCLES < 1 || STROBE_CYCLES > 15) $error("strobe length out of range");

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    wr_next = wr_reg;
    done_next = 1'b0;
    rdata_next = rdata_reg;
    dq_out_next = dq_out_reg;
    addr_next = addr_reg;
    dq_oe_n_next = dq_oe_n_reg;
    we_n_next = we_n_reg;
    oe_n_next = oe_n_reg;
    fsel_n_next = fsel_n_reg;
    rsel_n_next = rsel_n_reg;
    case (state_reg)
      S_IDLE:
      begin
        if (start)
        begin
          // selects fall first, so the strobe edges decide latching
          addr_next = addr;
          dq_out_next = wdata;
          wr_next = wr;
          dq_oe_n_next = !wr;
          fsel_n_next = !to_flash;
          rsel_n_next = to_flash;
          state_next = S_SETUP;
        end
      end
      S_SETUP:
      begin
        cnt_next = 4'h0;
        // write: strobe low, gate high; read: gate low, strobe high
        we_n_next = !wr_reg;
        oe_n_next = wr_reg;
        state_next = S_STROBE;
      end
      S_STROBE:
      begin
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == 4'(STROBE_CYCLES - 1))
        begin
          if (!wr_reg)
            rdata_next = dq_in;
          // strobe rises before the selects: data latched here
          we_n_next = 1'b1;
          oe_n_next = 1'b1;
          state_next = S_RECOVER;
        end
      end
      S_RECOVER:
      begin
        fsel_n_next = 1'b1;
        rsel_n_next = 1'b1;
        dq_oe_n_next = 1'b1;
        done_next = 1'b1;
        state_next = S_IDLE;
      end
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_reg <= S_IDLE;
      cnt_reg <= 4'h0;
      wr_reg <= 1'b0;
      done_reg <= 1'b0;
      rdata_reg <= 8'h00;
      dq_out_reg <= 8'h00;
      addr_reg <= 19'h0_0000;
      dq_oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      fsel_n_reg <= 1'b1;
      rsel_n_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      wr_reg <= wr_next;
      done_reg <= done_next;
      rdata_reg <= rdata_next;
      dq_out_reg <= dq_out_next;
      addr_reg <= addr_next;
      dq_oe_n_reg <= dq_oe_n_next;
      we_n_reg <= we_n_next;
      oe_n_reg <= oe_n_next;
      fsel_n_reg <= fsel_n_next;
      rsel_n_reg <= rsel_n_next;
    end
  end

  assign ready = (state_reg == S_IDLE);
  assign done = done_reg;
  assign rdata = rdata_reg;
  assign mem_addr = addr_reg;
  assign dq_out = dq_out_reg;
  assign dq_oe_n = dq_oe_n_reg;
  assign we_n = we_n_reg;
  assign oe_n = oe_n_reg;
  assign flash_bank_select_n = fsel_n_reg;
  assign ram_bank_select_n = rsel_n_reg;
  // reduced-pin part: the pin is the ram select in ram cycles, the gate in flash cycles
  assign shared_gate_select_pin = fsel_n_reg ? rsel_n_reg : oe_n_reg;

  //////////////////////////////////////////////////////////////////////////////
  // strobe length assumes STROBE_CYCLES of 3
  sequence s_strobe_low;
    !we_n_reg [*3] ##1 we_n_reg;
  endsequence
  sequence s_selects_up;
    ##1 (fsel_n_reg && rsel_n_reg);
  endsequence

  property p_no_dual_select;
    @(posedge clk) disable iff (!resetn) !(!fsel_n_reg && !rsel_n_reg);
  endproperty
  a_no_dual_select: assert property (p_no_dual_select) else $error("both bank selects low");

  property p_read_strobe_high;
    @(posedge clk) disable iff (!resetn) !oe_n_reg |-> we_n_reg && dq_oe_n_reg && !(fsel_n_reg && rsel_n_reg);
  endproperty
  a_read_strobe_high: assert property (p_read_strobe_high) else $error("read gate without clean read");

  property p_flash_read;
    @(posedge clk) disable iff (!resetn) $fell(oe_n_reg) && !fsel_n_reg |-> !oe_n_reg [*3] ##1 oe_n_reg ##1 fsel_n_reg;
  endproperty
  a_flash_read: assert property (p_flash_read) else $error("flash read gate malformed");

  property p_write_window;
    @(posedge clk) disable iff (!resetn) $fell(we_n_reg) |-> $past(!(fsel_n_reg && rsel_n_reg)) ##0 s_strobe_low ##0 s_selects_up;
  endproperty
  a_write_window: assert property (p_write_window) else $error("write window not inside selects");

  property p_gate_during_write;
    @(posedge clk) disable iff (!resetn) !we_n_reg |-> oe_n_reg && !dq_oe_n_reg;
  endproperty
  a_gate_during_write: assert property (p_gate_during_write) else $error("gate not high in write");

  property p_flash_command;
    @(posedge clk) disable iff (!resetn) $fell(we_n_reg) && !fsel_n_reg |-> $past(oe_n_reg, 1) && rsel_n_reg;
  endproperty
  a_flash_command: assert property (p_flash_command) else $error("flash command load malformed");
endmodule // flash_bus_cycle
`default_nettype wire

// >>> testbench/combo_mem_model.sv
// behavioural combined flash and static-ram device on the shared pins
`timescale 1ns/1ps
`default_nettype none
module combo_mem_model #(
  parameter int RAM_DEPTH = 131072
) (
  // shared pins
  input wire logic [18:0] mem_addr,
  input wire logic [7:0] dq_out,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic flash_bank_select_n,
  input wire logic ram_bank_select_n,
  input wire logic shared_gate_select_pin,
  output logic [7:0] dq_in
);
  logic [7:0] fl [int];
  logic [7:0] ram [int];
  logic [18:0] la = 19'h0_0000;
  logic [7:0] pd = 8'h00;
  logic [7:0] last = 8'h00;
  logic [7:0] rv;
  logic [2:0] step = 3'h0;
  logic busy = 1'b0;
  logic prog = 1'b0;
  logic tog = 1'b0;
  int prog_ns = 8000;
  int erase_ns = 50000;
  function automatic logic [7:0] frd(input logic [18:0] a);
    return fl.exists(a) ? fl[a] : 8'hff;
  endfunction
  ////////////////////////////////////////////////////////////////
  always @*
  begin
    if (!flash_bank_select_n)
      rv = busy ? {prog ? ~pd[7] : 1'b0, tog, 6'h00} : frd(mem_addr);
    else
      rv = ram.exists(mem_addr) ? ram[mem_addr] : 8'h00;
    // undriven bus shows the inverse of the last byte
    dq_in = (!oe_n && we_n && !shared_gate_select_pin
      && !(flash_bank_select_n && ram_bank_select_n)) ? rv : ~last;
  end
  always @(posedge oe_n)
  begin
    last = rv;
    if (!flash_bank_select_n && busy)
      tog = ~tog;
  end
  ////////////////////////////////////////////////////////////////
  task automatic launch(input logic p, input logic [7:0] d, input int ns);
    busy = 1'b1;
    prog = p;
    pd = d;
    busy <= #(ns) 1'b0;
  endtask
  task automatic load(input logic [18:0] a, input logic [7:0] d);
    logic ua;
    logic ub;
    ua = a == 19'h5_5555;
    ub = a == 19'h0_2aaa;
    if (busy)
      return;
    case (step)
      3'h0: step = (ua && d == 8'haa) ? 3'h1 : 3'h0;
      3'h4: step = (ua && d == 8'haa) ? 3'h5 : 3'h0;
      3'h1, 3'h5: step = (ub && d == 8'h55) ? step + 3'h1 : 3'h0;
      3'h2: step = !ua ? 3'h0 : (d == 8'ha0) ? 3'h3 : (d == 8'h80) ? 3'h4 : 3'h0;
      3'h3:
      begin
        fl[a] = frd(a) & d;
        launch(1'b1, d, prog_ns);
        step = 3'h0;
      end
      default:
      begin
        if (d == 8'h30)
        begin
          for (int i = 0; i < 4096; i++)
            fl.delete({a[18:12], 12'h000} + i);
          launch(1'b0, d, erase_ns);
        end
        else if (d == 8'h10 && ua)
        begin
          fl.delete();
          launch(1'b0, d, erase_ns);
        end
        step = 3'h0;
      end
    endcase
  endtask
  always @(negedge we_n)
    la = mem_addr;
  always @(posedge we_n)
  begin
    if (!flash_bank_select_n)
      load(la, dq_out);
    else if (!ram_bank_select_n)
      ram[la] = dq_out;
  end
endmodule // combo_mem_model
`default_nettype wire

// >>> testbench/flash_sram_combo_bus_interface_test.sv
// self-checking bench for the combined-memory host controller
`timescale 1ns/1ps
`default_nettype none
module flash_sram_combo_bus_interface_test;
  import combo_host_pkg::*;
  logic clk, resetn, cmd_valid, cmd_ready, resp_valid, resp_error, flash_busy, flash_done, flash_error;
  op_t cmd_op;
  logic [ADDR_W-1:0] cmd_addr, mem_addr;
  logic [DATA_W-1:0] cmd_wdata, resp_rdata, dq_in, dq_out;
  logic dq_oe_n, we_n, oe_n, flash_bank_select_n, ram_bank_select_n, shared_gate_select_pin;
  int failures = 0;
  int checked = 0;
  combo_mem_host #(.ERASE_TIMEOUT_CYCLES(2000)) combo_mem_host_i (.clk, .resetn, .cmd_valid, .cmd_ready, .cmd_op,
    .cmd_addr, .cmd_wdata, .resp_valid, .resp_error, .resp_rdata, .flash_busy, .flash_done, .flash_error, .mem_addr,
    .dq_in, .dq_out, .dq_oe_n, .we_n, .oe_n, .flash_bank_select_n, .ram_bank_select_n, .shared_gate_select_pin);
  combo_mem_model combo_mem_model_i (.mem_addr, .dq_out, .we_n, .oe_n, .flash_bank_select_n, .ram_bank_select_n,
    .shared_gate_select_pin, .dq_in);
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t bit got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // no contention between the banks or between host and device on the data lines
  always @(negedge clk)
  begin
    if (resetn && (!(flash_bank_select_n | ram_bank_select_n) || !(dq_oe_n | oe_n)))
      chk_bit(1'b1, 1'b0);
    if (shared_gate_select_pin !== (flash_bank_select_n ? ram_bank_select_n : oe_n))
      chk_bit(shared_gate_select_pin, ~shared_gate_select_pin);
  end
  ////////////////////////////////////////////////////////////////
  task automatic issue(input op_t op, input logic [18:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
  endtask
  // one ram or flash access; d is write data or expected read byte
  task automatic access(input op_t op, input logic [18:0] a, input logic [7:0] d, input logic err);
    int n;
    n = 0;
    issue(op, a, d);
    while (resp_valid !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_bit(resp_valid, 1'b1);
    chk_bit(resp_error, err);
    if (op != OP_RAM_WRITE && !err)
      chk_byte(resp_rdata, d);
  endtask
  task automatic wait_done(input logic err);
    int n;
    n = 0;
    while (flash_done !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_bit(flash_done, 1'b1);
    chk_bit(flash_error, err);
    @(posedge clk);
    #1;
    chk_bit(flash_busy, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_ram();
    access(OP_RAM_WRITE, 19'h1_ffff, 8'ha5, 1'b0);
    access(OP_RAM_WRITE, 19'h0_0000, 8'h3c, 1'b0);
    access(OP_RAM_READ, 19'h1_ffff, 8'ha5, 1'b0);
    access(OP_RAM_READ, 19'h0_0000, 8'h3c, 1'b0);
    access(OP_RAM_READ, 19'h2_0000, 8'h00, 1'b1);
    access(OP_FLASH_READ, 19'h1_ffff, 8'hff, 1'b0);
    $display("test ram done");
  endtask
  task automatic t_program(input logic [18:0] a, input logic [7:0] d);
    int n;
    n = 0;
    issue(OP_PROGRAM, a, d);
    while (flash_busy !== 1'b1 && n < 60)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_bit(flash_busy, 1'b1);
    chk_bit(cmd_ready, 1'b0);
    chk_bit(combo_mem_model_i.busy, 1'b1);
    access(OP_RAM_WRITE, 19'h0_0010, d, 1'b0);
    access(OP_RAM_READ, 19'h0_0010, d, 1'b0);
    wait_done(1'b0);
    chk_bit(combo_mem_model_i.busy, 1'b0);
    access(OP_FLASH_READ, a, d, 1'b0);
    $display("test program done");
  endtask
  task automatic t_erase(input op_t op, input logic [18:0] a, input logic [18:0] ra, input logic [7:0] rd);
    issue(op, a, 8'h00);
    wait_done(1'b0);
    access(OP_FLASH_READ, ra, rd, 1'b0);
    $display("test erase done");
  endtask
  task automatic t_timeout();
    combo_mem_model_i.prog_ns = 30000;
    issue(OP_PROGRAM, 19'h0_0100, 8'h00);
    wait_done(1'b1);
    $display("test timeout done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_RAM_READ;
    cmd_addr = 19'h0_0000;
    cmd_wdata = 8'h00;
    repeat (2) @(posedge clk);
    #1;
    resetn = 1'b1;
    chk_bit(flash_bank_select_n & ram_bank_select_n & we_n & oe_n & dq_oe_n, 1'b1);
    chk_bit(flash_busy | resp_valid | flash_done, 1'b0);
    t_ram();
    t_program(19'h4_1234, 8'h5a);
    t_program(19'h4_2000, 8'h00);
    t_erase(OP_SECTOR_ERASE, 19'h4_1234, 19'h4_1234, 8'hff);
    access(OP_FLASH_READ, 19'h4_2000, 8'h00, 1'b0);
    t_erase(OP_BANK_ERASE, 19'h0_0000, 19'h4_2000, 8'hff);
    t_timeout();
    print_verdict();
  end
  initial
  begin
    #(3000000);
    failures++;
    print_verdict();
  end
endmodule // flash_sram_combo_bus_interface_test
`default_nettype wire
